// file: drive_sequence_protection.sv
`timescale 1ns/1ps
module drive_sequence_protection
   import drive_prot_pkg::*;
#(
   parameter int                 LOSS_UNIT_CYC = drive_prot_pkg::LOSS_UNIT_CYCLES,
   parameter logic [31:0]        OL_HEAT_LIMIT = drive_prot_pkg::OL_HEAT_LIMIT_DEF,
   parameter logic [15:0]        OL_COOL_STEP  = drive_prot_pkg::OL_COOL_STEP_DEF
) (
   input  wire logic                                   clk_sys,
   input  wire logic                                   rst_b,
   input  wire logic [2:0]                             phase_open,
   input  wire logic                                   multi_input_4,
   input  wire logic                                   multi_input_5,
   input  wire logic                                   open_phase_protect_select,
   input  wire logic [drive_prot_pkg::FUNC_W-1:0]      input4_function_select,
   input  wire logic [drive_prot_pkg::FUNC_W-1:0]      input5_function_select,
   input  wire logic [drive_prot_pkg::FUNC_W-1:0]      relay_function_select,
   input  wire logic [drive_prot_pkg::FUNC_W-1:0]      output2_function_select,
   input  wire logic [drive_prot_pkg::CURR_W-1:0]      input_current,
   input  wire logic [drive_prot_pkg::CURR_W-1:0]      rated_current,
   input  wire logic [3:0]                             speed_source,
   input  wire drive_prot_pkg::loss_mode_t             loss_detect_mode,
   input  wire drive_prot_pkg::loss_react_t            loss_reaction_select,
   input  wire logic [drive_prot_pkg::TENTH_W-1:0]     loss_persist_time,
   input  wire logic [drive_prot_pkg::ANALOG_W-1:0]    voltage_analog_input,
   input  wire logic [drive_prot_pkg::ANALOG_W-1:0]    current_analog_input,
   input  wire logic [drive_prot_pkg::ANALOG_W-1:0]    voltage_in_threshold,
   input  wire logic [drive_prot_pkg::ANALOG_W-1:0]    voltage0_in_threshold,
   input  wire logic [drive_prot_pkg::ANALOG_W-1:0]    current_in_threshold,
   input  wire logic                                   comm_cmd_lost,
   input  wire logic                                   clear_req,
   output drive_prot_pkg::trip_flags_t                 trips,
   output logic                                        output_block,
   output logic                                        hold_freq,
   output logic                                        decel_stop,
   output logic                                        relay_out,
   output logic                                        output2_out
);
   import drive_prot_pkg::*;

   prot_state_t st;
   prot_state_t next_st;
   logic [4:0]  pins_s;
   logic [2:0]  phase_s;
   logic [1:0]  shorted;
   logic        open_cause;
   logic        a_cause;
   logic [1:0]  b_on;
   logic        b_clear_ok;
   logic        ol_cause;
   logic        loss_cond;
   logic        loss_on;

   // refuse a time base the prescaler cannot count, and a heat model that cannot work
   if (LOSS_UNIT_CYC < 1 || LOSS_UNIT_CYC >= (1 << PRE_W)) begin : g_bad_unit
      $error("drive_sequence_protection: LOSS_UNIT_CYC out of range");
   end
   if (OL_HEAT_LIMIT == 32'h0000_0000 || OL_COOL_STEP == 16'h0000) begin : g_bad_heat
      $error("drive_sequence_protection: overload heat settings out of range");
   end

   // trip latch: the cause sets, a clear only acts when the cause is gone
   function automatic logic trip_next(input logic cur, input logic cause, input logic clr);
      trip_next = cause | (cur & ~clr);
   endfunction : trip_next

   // analog level below the threshold chosen by the detection mode
   function automatic logic below(input logic [ANALOG_W-1:0] val,
                                  input logic [ANALOG_W-1:0] thr,
                                  input loss_mode_t          mode);
      unique case (mode)
         LOSS_DET_HALF: below = val < (thr >> 1);
         LOSS_DET_FULL: below = val < thr;
         default:       below = 1'b0;
      endcase
   endfunction : below

   // status selected for a relay or digital output by its function code
   function automatic logic out_sel(input logic [FUNC_W-1:0] code,
                                    input logic ol, input logic loss);
      if (code == OUT_INV_OVERLOAD) begin
         out_sel = ol;
      end else if (code == OUT_CMD_LOSS) begin
         out_sel = loss;
      end else begin
         out_sel = 1'b0;
      end
   endfunction : out_sel

   // contact and phase sense pins cross into the clock domain
   pin_sync #(.W(5)) u_pin_sync (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .async_in ({phase_open, multi_input_5, multi_input_4}),
      .sync_out (pins_s)
   );

   assign phase_s = pins_s[4:2];
   assign shorted = pins_s[1:0];

   // trip causes from phases, contacts and heat
   always_comb begin
      open_cause = open_phase_protect_select && (|phase_s);
      a_cause    = (input4_function_select == FN_EXT_TRIP_A && shorted[0])
                 | (input5_function_select == FN_EXT_TRIP_A && shorted[1]);
      b_on[0]    = (input4_function_select == FN_EXT_TRIP_B) && !shorted[0];
      b_on[1]    = (input5_function_select == FN_EXT_TRIP_B) && !shorted[1];
      if (st.extb_src) begin
         b_clear_ok = (input5_function_select == FN_EXT_TRIP_B) && shorted[1];
      end else begin
         b_clear_ok = (input4_function_select == FN_EXT_TRIP_B) && shorted[0];
      end
      ol_cause   = st.ol_acc >= OL_HEAT_LIMIT;
   end

   // speed command loss condition by source
   always_comb begin
      if (speed_source == SRC_V1) begin
         loss_cond = below(voltage_analog_input, voltage_in_threshold, loss_detect_mode);
      end else if (speed_source == SRC_I2) begin
         loss_cond = below(current_analog_input, current_in_threshold, loss_detect_mode);
      end else if (speed_source == SRC_V0_I2) begin
         loss_cond = below(voltage_analog_input, voltage0_in_threshold, loss_detect_mode)
                   | below(current_analog_input, current_in_threshold, loss_detect_mode);
      end else if (speed_source == SRC_COMM) begin
         loss_cond = comm_cmd_lost && (loss_detect_mode != LOSS_DET_OFF);
      end else begin
         loss_cond = 1'b0;
      end
   end

   // next state of every latch, counter and registered output
   always_comb begin
      next_st = st;
      loss_on = 1'b0;
      // inverse-time heat: excess current adds, normal current cools
      if (input_current > rated_current) begin
         next_st.ol_acc = (st.ol_acc > ~32'(input_current - rated_current))
                        ? '1 : st.ol_acc + 32'(input_current - rated_current);
      end else if (st.ol_acc > 32'(OL_COOL_STEP)) begin
         next_st.ol_acc = st.ol_acc - 32'(OL_COOL_STEP);
      end else begin
         next_st.ol_acc = '0;
      end
      // persistence timer of the loss condition
      unique case (st.loss_state)
         LOSS_IDLE: begin
            next_st.pre    = '0;
            next_st.tenths = '0;
            if (loss_cond) next_st.loss_state = LOSS_WAIT;
         end
         LOSS_WAIT: begin
            if (!loss_cond) begin
               next_st.loss_state = LOSS_IDLE;
            end else if (st.pre == PRE_W'(LOSS_UNIT_CYC - 1)) begin
               next_st.pre    = '0;
               next_st.tenths = st.tenths + 1'b1;
               if (st.tenths + 1'b1 >= loss_persist_time)
                  next_st.loss_state = LOSS_ACTIVE;
            end else begin
               next_st.pre = st.pre + 1'b1;
            end
         end
         LOSS_ACTIVE: begin
            loss_on = 1'b1;
            if (!loss_cond) next_st.loss_state = LOSS_IDLE;
         end
         default: next_st.loss_state = LOSS_IDLE;
      endcase
      // latched trips
      next_st.trips.open_phase = trip_next(st.trips.open_phase, open_cause, clear_req);
      next_st.trips.ext_a      = trip_next(st.trips.ext_a, a_cause, clear_req);
      next_st.trips.ext_b      = trip_next(st.trips.ext_b, |b_on,
                                           clear_req && b_clear_ok);
      next_st.trips.overload   = trip_next(st.trips.overload, ol_cause, clear_req);
      next_st.trips.cmd_loss   = trip_next(st.trips.cmd_loss,
                                           loss_on && loss_reaction_select == REACT_FREE_RUN,
                                           clear_req);
      if (|b_on && !st.trips.ext_b) next_st.extb_src = b_on[1];
      // configurable status outputs
      next_st.relay = out_sel(relay_function_select, next_st.trips.overload,
                              next_st.loss_state == LOSS_ACTIVE);
      next_st.out2  = out_sel(output2_function_select, next_st.trips.overload,
                              next_st.loss_state == LOSS_ACTIVE);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= PROT_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign trips        = st.trips;
   assign output_block = |st.trips;
   assign hold_freq    = (st.loss_state == LOSS_ACTIVE)
                       && (loss_reaction_select == REACT_CONTINUE);
   assign decel_stop   = (st.loss_state == LOSS_ACTIVE)
                       && (loss_reaction_select == REACT_DECEL);
   assign relay_out    = st.relay;
   assign output2_out  = st.out2;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_latched;
      output_block && !clear_req;
   endsequence

   sequence s_b_trip_moved;
      st.trips.ext_b && st.extb_src && input5_function_select != FN_EXT_TRIP_B;
   endsequence

   a_open_disabled: assert property (!st.trips.open_phase && !open_phase_protect_select
      |=> !st.trips.open_phase) else $error("open-phase trip while disabled");
   a_open_blocks: assert property (open_phase_protect_select && |phase_s
      |=> st.trips.open_phase && output_block) else $error("open phase not blocked");
   a_ext_a_trip: assert property (input4_function_select == FN_EXT_TRIP_A && shorted[0]
      |=> st.trips.ext_a ##0 output_block) else $error("trip A missed");
   a_ext_b_trip: assert property (input5_function_select == FN_EXT_TRIP_B && !shorted[1]
      |=> st.trips.ext_b) else $error("trip B missed");
   a_ext_b_stuck: assert property (s_b_trip_moved |=> st.trips.ext_b)
      else $error("trip B cleared after function change");
   a_overload_trip: assert property (st.ol_acc >= OL_HEAT_LIMIT |=> st.trips.overload)
      else $error("overload trip missed");
   a_overload_relay: assert property (st.trips.overload && relay_function_select ==
      OUT_INV_OVERLOAD && !clear_req |=> relay_out) else $error("overload relay missing");
   a_loss_mode_off: assert property (loss_detect_mode == LOSS_DET_OFF |-> !loss_cond)
      else $error("loss detected while disabled");
   a_loss_needs_cond: assert property ($rose(st.loss_state == LOSS_ACTIVE)
      |-> $past(loss_cond, 2) && $past(loss_cond)) else $error("loss without cause");
   a_loss_freerun: assert property (st.loss_state == LOSS_ACTIVE && loss_cond &&
      loss_reaction_select == REACT_FREE_RUN |=> st.trips.cmd_loss)
      else $error("free-run reaction missing");
   a_loss_out2: assert property (st.loss_state == LOSS_ACTIVE && loss_cond &&
      output2_function_select == OUT_CMD_LOSS |=> output2_out)
      else $error("loss output missing");
   a_trip_latched: assert property (s_latched |=> output_block)
      else $error("trip released without clear");

endmodule : drive_sequence_protection

// file: drive_prot_pkg.sv
package drive_prot_pkg;

   // clock and time base for the loss persistence timer
   localparam int CLK_HZ            = 50_000_000;
   localparam int LOSS_UNIT_MS      = 100;                       // one step of the loss time
   localparam int LOSS_UNIT_CYCLES  = CLK_HZ / 1000 * LOSS_UNIT_MS;
   localparam int LOSS_TIME_MAX     = 1200;                      // 120.0 s in 0.1 s steps
   localparam int LOSS_TIME_DEFAULT = 10;                        // 1.0 s in 0.1 s steps

   // widths
   localparam int ANALOG_W = 12;
   localparam int CURR_W   = 16;
   localparam int FUNC_W   = 5;
   localparam int PRE_W    = 23;
   localparam int TENTH_W  = 11;
   localparam int ACC_W    = 32;

   // overload heat model defaults
   localparam logic [ACC_W-1:0]  OL_HEAT_LIMIT_DEF = 32'h0100_0000;
   localparam logic [CURR_W-1:0] OL_COOL_STEP_DEF  = 16'h0001;

   // multi-function input codes
   localparam logic [FUNC_W-1:0] FN_EXT_TRIP_A = 5'h12;
   localparam logic [FUNC_W-1:0] FN_EXT_TRIP_B = 5'h13;

   // relay / digital output codes
   localparam logic [FUNC_W-1:0] OUT_INV_OVERLOAD = 5'h06;
   localparam logic [FUNC_W-1:0] OUT_CMD_LOSS     = 5'h0B;

   // speed command sources
   localparam logic [3:0] SRC_V1    = 4'h3;
   localparam logic [3:0] SRC_I2    = 4'h5;
   localparam logic [3:0] SRC_V0_I2 = 4'h6;
   localparam logic [3:0] SRC_COMM  = 4'h8;

   typedef enum logic [1:0] {
      LOSS_DET_OFF  = 2'h0,
      LOSS_DET_HALF = 2'h1,
      LOSS_DET_FULL = 2'h2
   } loss_mode_t;

   typedef enum logic [1:0] {
      REACT_CONTINUE = 2'h0,
      REACT_FREE_RUN = 2'h1,
      REACT_DECEL    = 2'h2
   } loss_react_t;

   typedef enum logic [2:0] {
      LOSS_IDLE   = 3'h1,
      LOSS_WAIT   = 3'h2,
      LOSS_ACTIVE = 3'h4
   } loss_state_t;

   typedef struct packed {
      logic open_phase;
      logic ext_a;
      logic ext_b;
      logic overload;
      logic cmd_loss;
   } trip_flags_t;

   typedef struct packed {
      trip_flags_t        trips;
      logic               extb_src;    // 0: input 4, 1: input 5
      logic [ACC_W-1:0]   ol_acc;
      loss_state_t        loss_state;
      logic [PRE_W-1:0]   pre;
      logic [TENTH_W-1:0] tenths;
      logic               relay;
      logic               out2;
   } prot_state_t;

   localparam prot_state_t PROT_RESET = '{
      trips: '0, extb_src: 1'b0, ol_acc: '0, loss_state: LOSS_IDLE,
      pre: '0, tenths: '0, relay: 1'b0, out2: 1'b0};

endpackage : drive_prot_pkg

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 5
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // refuse a width that leaves nothing to synchronise
   if (W < 1) begin : g_bad_width
      $error("pin_sync: width must be at least one");
   end

   // two stages; only the second stage is read outside
   always_comb begin
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   // stages keep tracking the pins in reset: a cleared stage would look like an
   // open trip B contact for two cycles after release and latch a false trip
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '{s1: async_in, s2: st.s1};
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;

endmodule : pin_sync

// file: field_model.sv
`timescale 1ns/1ps
// far side of the block: motor phases, trip contacts and analog command wiring
module field_model #(
   parameter int W = drive_prot_pkg::ANALOG_W
) (
   input  wire logic         clk_sys,
   input  wire logic [2:0]   cut,
   input  wire logic [1:0]   shorted,
   input  wire logic [W-1:0] v_lvl,
   input  wire logic [W-1:0] i_lvl,
   output logic      [2:0]   phase_open,
   output logic              multi_input_4,
   output logic              multi_input_5,
   output logic      [W-1:0] voltage_analog_input,
   output logic      [W-1:0] current_analog_input
);
   // wiring follows the field one cycle later, like a real cable and contact
   always_ff @(posedge clk_sys) begin
      phase_open <= cut;
      multi_input_4 <= shorted[0];
      multi_input_5 <= shorted[1];
      voltage_analog_input <= v_lvl;
      current_analog_input <= i_lvl;
   end
endmodule : field_model

// file: drive_sequence_protection_tb.sv
`timescale 1ns/1ps
module drive_sequence_protection_tb;
   import drive_prot_pkg::*;
   typedef struct packed {
      logic        s;
      logic [2:0]  ph;
      logic [1:0]  sh;
      logic [4:0]  fa;
      logic [4:0]  fb;
      trip_flags_t e;
   } row_t;
   logic        clk_sys, rst_b, sel, clear_req, comm;
   logic [2:0]  cut, phase_open;
   logic [1:0]  sh;
   logic        multi_input_4, multi_input_5;
   logic [11:0] v_lvl, i_lvl, voltage_analog_input, current_analog_input;
   logic [11:0] vth, v0th, ith;
   logic [4:0]  f4, f5, rf, of;
   logic [15:0] cur, rated;
   logic [3:0]  src;
   logic [10:0] pers;
   loss_mode_t  mode;
   loss_react_t react;
   trip_flags_t trips;
   logic        output_block, hold_freq, decel_stop, relay_out, output2_out;
   int          bad_count, n_tests;
   // select, phases, contacts, input 4/5 functions, expected trips
   row_t rows [8] = '{
      '{1'h1, 3'h1, 2'h2, 5'h12, 5'h13, 5'h10}, '{1'h0, 3'h2, 2'h2, 5'h12, 5'h13, 5'h00},
      '{1'h1, 3'h4, 2'h2, 5'h12, 5'h13, 5'h10}, '{1'h0, 3'h0, 2'h3, 5'h12, 5'h13, 5'h08},
      '{1'h0, 3'h0, 2'h0, 5'h12, 5'h13, 5'h04}, '{1'h0, 3'h0, 2'h3, 5'h00, 5'h13, 5'h00},
      '{1'h0, 3'h0, 2'h3, 5'h12, 5'h12, 5'h08}, '{1'h1, 3'h2, 2'h2, 5'h12, 5'h13, 5'h10}};

   field_model fm (.clk_sys, .cut, .shorted(sh), .v_lvl, .i_lvl, .phase_open,
      .multi_input_4, .multi_input_5, .voltage_analog_input, .current_analog_input);

   drive_sequence_protection #(.LOSS_UNIT_CYC(4), .OL_HEAT_LIMIT(32'h0000_0100),
      .OL_COOL_STEP(16'h0001)) uut (
      .clk_sys, .rst_b, .phase_open, .multi_input_4, .multi_input_5,
      .open_phase_protect_select(sel), .input4_function_select(f4),
      .input5_function_select(f5), .relay_function_select(rf),
      .output2_function_select(of), .input_current(cur), .rated_current(rated),
      .speed_source(src), .loss_detect_mode(mode), .loss_reaction_select(react),
      .loss_persist_time(pers), .voltage_analog_input, .current_analog_input,
      .voltage_in_threshold(vth), .voltage0_in_threshold(v0th),
      .current_in_threshold(ith), .comm_cmd_lost(comm), .clear_req, .trips,
      .output_block, .hold_freq, .decel_stop, .relay_out, .output2_out);

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : w

   task automatic chk(input string nm, input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
      end
   endtask : chk

   task automatic chkt(input trip_flags_t e);
      for (int b = 0; b < 5; b++) chk("trips bit", trips[b], e[b]);
      chk("output_block", output_block, |e);
   endtask : chkt

   // one-cycle clear pulse
   task automatic clr();
      @(posedge clk_sys) clear_req <= 1'b1;
      @(posedge clk_sys) clear_req <= 1'b0;
   endtask : clr

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // loss case: apply levels, check relay and output2 stay low early, then reaction and indication
   task automatic lc(input logic [3:0] s, input logic [1:0] m, input logic [1:0] r,
                     input logic [11:0] v, input logic [11:0] i, input logic e);
      @(posedge clk_sys);
      src <= s;
      mode <= loss_mode_t'(m);
      react <= loss_react_t'(r);
      v_lvl <= v;
      i_lvl <= i;
      w(6);
      chk("relay early", relay_out, 1'b0);
      chk("output2 early", output2_out, 1'b0);
      w(8);
      chk("relay loss", relay_out, e && rf == 5'h0b);
      chk("output2 loss", output2_out, e && of == 5'h0b);
      chk("hold_freq", hold_freq, e && r == 2'h0);
      chk("decel_stop", decel_stop, e && r == 2'h2);
      chk("loss trip", trips.cmd_loss, e && r == 2'h1);
      @(posedge clk_sys) v_lvl <= 12'h800;
      i_lvl <= 12'h800;
      comm <= 1'b0;
      w(3);
      clr();
      w(2);
      chkt('0);
      chk("relay idle", relay_out, 1'b0);
      chk("output2 idle", output2_out, 1'b0);
      $display("loss case %0h/%0h/%0h done", s, m, r);
   endtask : lc

   // overload trip then cool down with clear held
   task automatic ol(input logic [15:0] c, input int t0, input int t1);
      @(posedge clk_sys) cur <= c;
      w(t0);
      chk("overload early", trips.overload, 1'b0);
      w(t1);
      chk("overload", trips.overload, 1'b1);
      chk("relay overload", relay_out, rf == 5'h06);
      chk("output2 overload", output2_out, of == 5'h06);
      chk("block", output_block, 1'b1);
      @(posedge clk_sys) cur <= 16'h0800;
      clear_req <= 1'b1;
      w(700);
      chk("overload cleared", trips.overload, 1'b0);
      @(posedge clk_sys) clear_req <= 1'b0;
      $display("overload case done");
   endtask : ol

   // watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      bad_count = 0;
      n_tests = 0;
      rst_b <= 1'b0;
      {sel, clear_req, comm} <= 3'h0;
      cut <= 3'h0;
      sh <= 2'h2;
      {v_lvl, i_lvl} <= {12'h800, 12'h800};
      {vth, v0th, ith} <= {12'h100, 12'h200, 12'h100};
      {f4, f5, rf, of} <= {5'h12, 5'h13, 5'h0b, 5'h06};
      {cur, rated} <= {16'h0800, 16'h1000};
      src <= 4'h0;
      pers <= 11'h002;
      mode <= LOSS_DET_OFF;
      react <= REACT_CONTINUE;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      w(4);
      chkt('0);
      chk("relay reset", relay_out, 1'b0);
      chk("output2 reset", output2_out, 1'b0);
      $display("reset test done");
      foreach (rows[k]) begin
         @(posedge clk_sys) sel <= rows[k].s;
         {cut, sh, f4, f5} <= {rows[k].ph, rows[k].sh, rows[k].fa, rows[k].fb};
         w(5);
         chkt(rows[k].e);
         clr();
         w(1);
         chkt(rows[k].e);
         @(posedge clk_sys) {cut, sh} <= {3'h0, 2'h2};
         w(5);
         @(posedge clk_sys) {f4, f5} <= {5'h12, 5'h13};
         w(1);
         clr();
         w(2);
         chkt('0);
         $display("row %0d done", k);
      end
      lc(4'h3, 2'h1, 2'h0, 12'h07f, 12'h800, 1'b1);
      lc(4'h3, 2'h1, 2'h0, 12'h080, 12'h800, 1'b0);
      lc(4'h3, 2'h2, 2'h2, 12'h0ff, 12'h800, 1'b1);
      lc(4'h6, 2'h2, 2'h1, 12'h1ff, 12'h800, 1'b1);
      lc(4'h6, 2'h2, 2'h0, 12'h800, 12'h0ff, 1'b1);
      lc(4'h3, 2'h0, 2'h0, 12'h000, 12'h800, 1'b0);
      lc(4'h0, 2'h2, 2'h0, 12'h000, 12'h000, 1'b0);
      @(posedge clk_sys) comm <= 1'b1;
      lc(4'h8, 2'h1, 2'h0, 12'h800, 12'h800, 1'b1);
      // condition drop restarts the persistence timer
      @(posedge clk_sys) {src, pers, v_lvl} <= {4'h3, 11'h003, 12'h0ff};
      mode <= LOSS_DET_FULL;
      w(6);
      @(posedge clk_sys) v_lvl <= 12'h800;
      w(2);
      @(posedge clk_sys) v_lvl <= 12'h0ff;
      w(10);
      chk("relay restart", relay_out, 1'b0);
      w(8);
      chk("relay after", relay_out, 1'b1);
      @(posedge clk_sys) v_lvl <= 12'h800;
      w(3);
      $display("restart test done");
      ol(16'h1040, 4, 1);
      // swap the output functions so each output shows both statuses
      @(posedge clk_sys) {rf, of} <= {5'h06, 5'h0b};
      ol(16'h1010, 16, 1);
      lc(4'h5, 2'h2, 2'h0, 12'h800, 12'h0ff, 1'b1);
      // trip B survives a function change, clears once restored
      @(posedge clk_sys) sh <= 2'h0;
      w(5);
      chk("ext_b", trips.ext_b, 1'b1);
      @(posedge clk_sys) sh <= 2'h2;
      f5 <= 5'h00;
      w(5);
      clr();
      w(2);
      chk("ext_b kept", trips.ext_b, 1'b1);
      @(posedge clk_sys) f5 <= 5'h13;
      w(1);
      clr();
      w(2);
      chk("ext_b cleared", trips.ext_b, 1'b0);
      $display("trip b test done");
      // reset in mid-run drops a latched trip
      @(posedge clk_sys) sh <= 2'h0;
      w(5);
      chk("ext_b before reset", trips.ext_b, 1'b1);
      @(posedge clk_sys) rst_b <= 1'b0;
      sh <= 2'h2;
      w(4);
      chkt('0);
      @(posedge clk_sys) rst_b <= 1'b1;
      w(5);
      chkt('0);
      $display("mid reset test done");
      print_verdict();
   end
endmodule : drive_sequence_protection_tb
